// [inc/irq_master_pkg.sv]
`default_nettype none
// Behaviour
// RULE_01: Enable or return instruction sets global enable.
// RULE_02: Control write loads global enable bit directly.
// RULE_03: Disable, acknowledge and reset clear global enable.
// RULE_04: Global enable low blocks interrupts to core; traps still reach the core here.
// RULE_05: Control bits six to zero read zero.
// RULE_06: Control register at fcf, resets to zero.
// RULE_07: Vector fetches use fixed program memory words.
// RULE_08: Some pins request on one chosen edge.
// RULE_09: Other pins request on every edge.
// RULE_10: Requests stay latched while global enable low.
package irq_master_pkg;

    // ********************************
    // Bus shape
    // ********************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_PINS = 8;
    localparam int NUM_SINGLE_EDGE = 4; // Pins below this index
    localparam int NUM_TRAPS = 4;

    // ********************************
    // Register offsets
    // ********************************
    localparam logic [11:0] OFS_MASTER_CTL = 12'hfcf;
    localparam logic [11:0] OFS_STATUS = 12'hfc0;
    localparam logic [11:0] OFS_MASK = 12'hfc1;
    localparam logic [11:0] OFS_EDGE_SEL = 12'hfc2;
    localparam logic [11:0] OFS_TRAP = 12'hfc3;

    // ********************************
    // Fields and reset values
    // ********************************
    localparam int GIE_BIT = 7;
    localparam logic [7:0] MASTER_CTL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] EDGE_SEL_RESET = 8'h00;
    localparam logic [3:0] TRAP_RESET = 4'h0;
    // Trap slots, in priority order
    localparam int TRAP_ILLEGAL = 0;
    localparam int TRAP_OSC_FAIL = 1;
    localparam int TRAP_WDT_OSC_FAIL = 2;
    localparam int TRAP_WDT = 3;

    // ********************************
    // Program memory vector words
    // ********************************
    localparam logic [15:0] VEC_RESET = 16'h0002;
    localparam logic [15:0] VEC_WATCHDOG = 16'h0004;
    localparam logic [15:0] VEC_ILLEGAL = 16'h0006;
    localparam logic [15:0] VEC_PERIPH_BASE = 16'h0008;
    localparam logic [15:0] VEC_PERIPH_LAST = 16'h0037;
    localparam logic [15:0] VEC_OSC_FAIL = 16'h003a;
    localparam logic [15:0] VEC_WDT_OSC_FAIL = 16'h003c;

endpackage
`default_nettype wire

// [inc/pin_event_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Pin levels and edge choices in, one-cycle edge events out
interface pin_event_if;
    logic [7:0] level; // Pin levels, synchronous
    logic [7:0] rise_sel; // 1 rising, 0 falling
    logic [7:0] event_hit; // Edge seen this cycle
    modport detector (input level, input rise_sel, output event_hit);
    modport consumer (output level, output rise_sel, input event_hit);
endinterface
`default_nettype wire

// [design/pin_edge_detect.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect
    import irq_master_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    pin_event_if.detector pins
);

    // ********************************
    // Edge history
    // ********************************
    logic [7:0] prev_reg; // Level seen last cycle
    logic armed_reg; // History valid
    wire logic [7:0] rise_w; // Low to high
    wire logic [7:0] fall_w; // High to low

    // First cycle after reset only loads history, so a pin
    // already high at release raises no false edge
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            prev_reg <= 8'h00;
            armed_reg <= 1'b0;
        end else begin
            prev_reg <= pins.level;
            armed_reg <= 1'b1;
        end
    end

    assign rise_w = armed_reg ? (pins.level & ~prev_reg) : 8'h00;
    assign fall_w = armed_reg ? (~pins.level & prev_reg) : 8'h00;

    // ********************************
    // Per-pin edge choice
    // ********************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            if (gi < NUM_SINGLE_EDGE) begin : g_one
                // One chosen edge
                assign pins.event_hit[gi] = pins.rise_sel[gi] ? rise_w[gi] : fall_w[gi]; // RULE_08
            end else begin : g_any
                // Either edge
                assign pins.event_hit[gi] = rise_w[gi] | fall_w[gi]; // RULE_09
            end
        end
    endgenerate

    // ********************************
    // Checks
    // ********************************
    property p_single_edge;
        @(posedge clk_sys_in) disable iff (rst_in)
        (armed_reg && pins.rise_sel[0] && $rose(pins.level[0])) |-> pins.event_hit[0];
    endproperty
    a_single_edge: assert property (p_single_edge) else $error("Chosen edge lost"); // RULE_08

    property p_any_edge;
        @(posedge clk_sys_in) disable iff (rst_in)
        (armed_reg && $fell(pins.level[5])) |-> pins.event_hit[5];
    endproperty
    a_any_edge: assert property (p_any_edge) else $error("Falling edge lost"); // RULE_09

endmodule
`default_nettype wire

// [design/interrupt_master_enable_vectors.sv]
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module interrupt_master_enable_vectors (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Register port
    input wire logic [irq_master_pkg::ADDR_W-1:0] addr_in,
    input wire logic [irq_master_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [irq_master_pkg::DATA_W-1:0] rdata_out,
    // Core instruction strobes
    input wire logic enable_irq_instruction_in,
    input wire logic disable_irq_instruction_in,
    input wire logic irq_return_instruction_in,
    input wire logic irq_ack_in,
    // Request sources
    input wire logic [irq_master_pkg::NUM_PINS-1:0] pin_in,
    input wire logic watchdog_counter_event_in,
    input wire logic illegal_instr_in,
    input wire logic osc_fail_in,
    input wire logic wdt_osc_fail_in,
    // To the core
    output logic core_irq_out,
    output logic [15:0] vector_addr_out,
    output logic irq_out
);
    import irq_master_pkg::*;

    // ********************************
    // Helpers
    // ********************************

    // Lowest set bit wins; index of it
    function automatic logic [2:0] first_pin(input logic [7:0] req);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_PINS - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // Pin vector word, two bytes per source
    function automatic logic [15:0] pin_vector(input logic [2:0] idx);
        return VEC_PERIPH_BASE + {12'h000, idx, 1'b0};
    endfunction

    // Trap vector word by slot
    function automatic logic [15:0] trap_vector(input logic [1:0] slot);
        logic [15:0] v;
        v = VEC_WATCHDOG;
        unique case (slot)
            2'd0: v = VEC_ILLEGAL;
            2'd1: v = VEC_OSC_FAIL;
            2'd2: v = VEC_WDT_OSC_FAIL;
            2'd3: v = VEC_WATCHDOG;
        endcase
        return v;
    endfunction

    // Lowest set trap slot
    function automatic logic [1:0] first_trap(input logic [3:0] req);
        logic [1:0] s;
        s = 2'd0;
        for (int i = NUM_TRAPS - 1; i >= 0; i--) begin
            if (req[i]) begin
                s = 2'(i);
            end
        end
        return s;
    endfunction

    // ********************************
    // State
    // ********************************
    logic gie_reg; // Global enable
    logic gie_next;
    logic [7:0] status_reg; // Sticky pin requests
    logic [7:0] status_next;
    logic [7:0] mask_reg; // Per-pin mask
    logic [7:0] mask_next;
    logic [7:0] edge_sel_reg; // Edge choice, low pins
    logic [7:0] edge_sel_next;
    logic [3:0] trap_reg; // Latched traps
    logic [3:0] trap_next;
    logic [11:0] grant_reg; // Source now offered
    logic [11:0] grant_next;
    logic [15:0] vector_reg; // Word for the fetch
    logic [15:0] vector_next;
    logic core_irq_reg; // Request to core
    logic core_irq_next;
    logic irq_reg; // Unmasked pending
    logic irq_next;
    logic [7:0] rdata_reg; // Read answer
    logic [7:0] rdata_next;

    // ********************************
    // Edge detection
    // ********************************
    pin_event_if pin_bus ();

    assign pin_bus.level = pin_in;
    assign pin_bus.rise_sel = edge_sel_reg;

    pin_edge_detect u_edges (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pins(pin_bus)
    );

    // ********************************
    // Address decode
    // ********************************
    wire logic sel_ctl = (addr_in == OFS_MASTER_CTL); // RULE_06
    wire logic sel_status = (addr_in == OFS_STATUS);
    wire logic sel_mask = (addr_in == OFS_MASK);
    wire logic sel_edge = (addr_in == OFS_EDGE_SEL);
    wire logic sel_trap = (addr_in == OFS_TRAP);
    wire logic wr_ctl = wr_in && sel_ctl;
    wire logic wr_status = wr_in && sel_status;
    wire logic wr_mask = wr_in && sel_mask;
    wire logic wr_edge = wr_in && sel_edge;
    wire logic wr_trap = wr_in && sel_trap;

    // ********************************
    // Global enable
    // ********************************
    wire logic gie_clr = disable_irq_instruction_in || irq_ack_in;
    wire logic gie_set = enable_irq_instruction_in || irq_return_instruction_in;

    // Clears beat sets, sets beat a plain write: an
    // acknowledge must never leave the core re-enabled
    always_comb begin
        gie_next = gie_reg;
        if (gie_clr) begin
            gie_next = 1'b0; // RULE_03
        end else if (gie_set) begin
            gie_next = 1'b1; // RULE_01
        end else if (wr_ctl) begin
            gie_next = wdata_in[GIE_BIT]; // RULE_02
        end
    end

    // ********************************
    // Request latches
    // ********************************
    wire logic [7:0] ack_pin_clr = irq_ack_in ? grant_reg[11:4] : 8'h00;
    wire logic [3:0] ack_trap_clr = irq_ack_in ? grant_reg[3:0] : 4'h0;
    wire logic [7:0] sw_pin_clr = wr_status ? wdata_in : 8'h00;
    wire logic [3:0] sw_trap_clr = wr_trap ? wdata_in[3:0] : 4'h0;
    wire logic [3:0] trap_hit = {watchdog_counter_event_in, wdt_osc_fail_in,
                                 osc_fail_in, illegal_instr_in};

    // New edges win over any clear in the same cycle; bits
    // survive while the global enable is low
    assign status_next = (status_reg & ~sw_pin_clr & ~ack_pin_clr)
                         | pin_bus.event_hit; // RULE_10
    assign trap_next = (trap_reg & ~sw_trap_clr & ~ack_trap_clr) | trap_hit;
    assign mask_next = wr_mask ? wdata_in : mask_reg;
    assign edge_sel_next = wr_edge ? wdata_in : edge_sel_reg;

    // ********************************
    // Source selection
    // ********************************
    wire logic [7:0] pend_next = status_next & mask_next;
    wire logic pin_any = |pend_next;
    wire logic trap_any = |trap_next;
    wire logic [2:0] pin_idx = first_pin(pend_next);
    wire logic [1:0] trap_idx = first_trap(trap_next);
    wire logic pin_ok = gie_next && pin_any; // RULE_04

    // Traps are not gated by the global enable; pins are.
    // Vector holds the last offer when nothing is pending.
    always_comb begin
        grant_next = 12'h000;
        vector_next = vector_reg;
        if (trap_any) begin
            grant_next[trap_idx] = 1'b1;
            vector_next = trap_vector(trap_idx); // RULE_07
        end else if (pin_ok) begin
            grant_next[4 + pin_idx] = 1'b1;
            vector_next = pin_vector(pin_idx); // RULE_07
        end
    end

    assign core_irq_next = trap_any || pin_ok; // RULE_04
    assign irq_next = pin_any;

    // ********************************
    // Read mux
    // ********************************
    wire logic [7:0] ctl_view = {gie_reg, 7'h00}; // RULE_05
    wire logic [7:0] rd_mux = sel_ctl ? ctl_view :
                              sel_status ? status_reg :
                              sel_mask ? mask_reg :
                              sel_edge ? edge_sel_reg :
                              sel_trap ? {4'h0, trap_reg} : 8'h00;

    // Data stand for one cycle only, zero otherwise
    assign rdata_next = rd_in ? rd_mux : 8'h00;

    // ********************************
    // Registers
    // ********************************

    // Control and request state
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            gie_reg <= MASTER_CTL_RESET[GIE_BIT]; // RULE_03
            status_reg <= STATUS_RESET;
            mask_reg <= MASK_RESET;
            edge_sel_reg <= EDGE_SEL_RESET;
            trap_reg <= TRAP_RESET;
        end else begin
            gie_reg <= gie_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            edge_sel_reg <= edge_sel_next;
            trap_reg <= trap_next;
        end
    end

    // Core-facing outputs; reset offers the reset word
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            grant_reg <= 12'h000;
            vector_reg <= VEC_RESET; // RULE_07
            core_irq_reg <= 1'b0;
            irq_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            grant_reg <= grant_next;
            vector_reg <= vector_next;
            core_irq_reg <= core_irq_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign core_irq_out = core_irq_reg;
    assign vector_addr_out = vector_reg;
    assign irq_out = irq_reg;
    assign rdata_out = rdata_reg;

    // ********************************
    // Checks
    // ********************************
    property p_gie_set;
        @(posedge clk_sys_in) disable iff (rst_in)
        (gie_set && !gie_clr) |=> gie_reg;
    endproperty
    a_gie_set: assert property (p_gie_set) else $error("Enable not set"); // RULE_01

    property p_gie_write;
        @(posedge clk_sys_in) disable iff (rst_in)
        (wr_ctl && !gie_set && !gie_clr) |=> (gie_reg == $past(wdata_in[GIE_BIT]));
    endproperty
    a_gie_write: assert property (p_gie_write) else $error("Write not loaded"); // RULE_02

    property p_gie_clear;
        @(posedge clk_sys_in) disable iff (rst_in)
        gie_clr |=> !gie_reg ##1 (!gie_reg || $past(gie_set || wr_ctl));
    endproperty
    a_gie_clear: assert property (p_gie_clear) else $error("Enable not cleared"); // RULE_03

    property p_gate;
        @(posedge clk_sys_in) disable iff (rst_in)
        (core_irq_out && trap_reg == 4'h0) |-> gie_reg;
    endproperty
    a_gate: assert property (p_gate) else $error("Request passed disabled gate"); // RULE_04

    property p_reserved;
        @(posedge clk_sys_in) disable iff (rst_in)
        (rd_in && sel_ctl) |=> (rdata_out[6:0] == 7'h00);
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bits not zero"); // RULE_05

    property p_ctl_read;
        @(posedge clk_sys_in) disable iff (rst_in)
        (rd_in && addr_in == 12'hfcf) |=> (rdata_out[7] == $past(gie_reg));
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("Control read wrong"); // RULE_06

    property p_pin_vector;
        @(posedge clk_sys_in) disable iff (rst_in)
        (core_irq_out && trap_reg == 4'h0) |->
            (vector_addr_out >= 16'h0008 && vector_addr_out <= 16'h0037 && !vector_addr_out[0]);
    endproperty
    a_pin_vector: assert property (p_pin_vector) else $error("Pin vector out of range"); // RULE_07

    property p_latched;
        @(posedge clk_sys_in) disable iff (rst_in)
        (!gie_reg && (status_reg & mask_reg) != 8'h00 && !wr_status && !wr_mask && !irq_ack_in)
            |=> irq_out ##0 ((status_reg & mask_reg) != 8'h00);
    endproperty
    a_latched: assert property (p_latched) else $error("Request dropped while disabled"); // RULE_10

    c_pin_taken: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        core_irq_out && irq_ack_in && grant_reg[11:4] != 8'h00);
    c_trap_taken: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        core_irq_out && irq_ack_in && grant_reg[3:0] != 4'h0);
    c_held_then_sent: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        (irq_out && !gie_reg) ##1 gie_set ##1 core_irq_out);

endmodule
`default_nettype wire

// [verif/core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Processor core stand-in
// ****************************************
// Accepts an offered request after a set wait and notes the vector it fetched
module core_model (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic core_irq_in,
    input wire logic [15:0] vector_in,
    input wire logic ack_en_in,
    input wire logic [3:0] ack_delay_in,
    output logic irq_ack_out,
    output logic [15:0] taken_vector_out,
    output logic taken_out
);
    logic [3:0] wait_reg; // Cycles the offer has stood

    // Ack only while the offer is high; the cycle after an ack is skipped,
    // because the offer is registered and still shows high there
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wait_reg <= 4'h0;
            irq_ack_out <= 1'b0;
            taken_out <= 1'b0;
            taken_vector_out <= 16'h0000;
        end else begin
            irq_ack_out <= 1'b0;
            taken_out <= 1'b0;
            if (irq_ack_out) begin
                wait_reg <= 4'h0;
            end else if (core_irq_in && ack_en_in) begin
                if (wait_reg == ack_delay_in) begin
                    irq_ack_out <= 1'b1;
                    taken_out <= 1'b1;
                    taken_vector_out <= vector_in;
                    wait_reg <= 4'h0;
                end else begin
                    wait_reg <= wait_reg + 4'h1;
                end
            end else begin
                wait_reg <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/interrupt_master_enable_vectors_test.sv]
`timescale 1ns/1ps
`default_nettype none
module interrupt_master_enable_vectors_test;
    import irq_master_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [11:0] addr_in = 12'h000;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic [7:0] strb = 8'h00; // Core strobes and trap pulses, one bit each
    logic [7:0] pin_in = 8'h00;
    logic irq_ack_in;
    logic core_irq_out;
    logic irq_out;
    logic [15:0] vector_addr_out;
    logic ack_en = 1'b0; // Core model answers only when set
    logic [3:0] ack_delay = 4'h0;
    logic [15:0] taken_vector;
    logic taken;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;

    // ****************************************
    // Clock and instances
    // ****************************************
    always #12.5 clk_sys_in = ~clk_sys_in; // 40 MHz

    interrupt_master_enable_vectors interrupt_master_enable_vectors_inst (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .enable_irq_instruction_in(strb[0]), .disable_irq_instruction_in(strb[1]),
        .irq_return_instruction_in(strb[2]), .irq_ack_in(irq_ack_in), .pin_in(pin_in),
        .watchdog_counter_event_in(strb[3]), .illegal_instr_in(strb[4]),
        .osc_fail_in(strb[5]), .wdt_osc_fail_in(strb[6]),
        .core_irq_out(core_irq_out), .vector_addr_out(vector_addr_out), .irq_out(irq_out));

    core_model core_model_inst (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .core_irq_in(core_irq_out),
        .vector_in(vector_addr_out), .ack_en_in(ack_en), .ack_delay_in(ack_delay),
        .irq_ack_out(irq_ack_in), .taken_vector_out(taken_vector), .taken_out(taken));

    // ****************************************
    // Compare and bus tasks
    // ****************************************
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    task automatic pulse(input int b);
        @(posedge clk_sys_in);
        strb[b] <= 1'b1;
        @(posedge clk_sys_in);
        strb[b] <= 1'b0;
    endtask

    // Three cycles covers edge detect, status set and the registered outputs
    task automatic set_pin(input int i, input logic v);
        @(posedge clk_sys_in);
        pin_in[i] <= v;
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask

    // Bounded wait for the core model to take an offer
    task automatic wait_take(output logic got);
        got = 1'b0;
        repeat (20) begin
            @(posedge clk_sys_in);
            #1;
            if (taken === 1'b1) begin
                got = 1'b1;
                break;
            end
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        logic [7:0] d;
        reg_rd(OFS_MASTER_CTL, d);
        chk_reg(d, 8'h00, "ctl after reset");
        chk_bit(core_irq_out, 1'b0, "offer after reset");
        chk_vec(vector_addr_out, VEC_RESET, "reset vector");
        $display("test reset done");
    endtask

    task automatic t_write;
        logic [7:0] d;
        reg_wr(OFS_MASTER_CTL, 8'h80);
        reg_rd(OFS_MASTER_CTL, d);
        chk_reg(d, 8'h80, "write one");
        reg_wr(OFS_MASTER_CTL, 8'h00);
        reg_rd(OFS_MASTER_CTL, d);
        chk_reg(d, 8'h00, "write zero");
        // Refused case: reserved bits written with ones must stay zero
        reg_wr(OFS_MASTER_CTL, 8'hff);
        reg_rd(OFS_MASTER_CTL, d);
        chk_reg(d, 8'h80, "reserved bits");
        reg_wr(OFS_MASTER_CTL, 8'h00);
        reg_rd(12'hfce, d);
        chk_reg(d, 8'h00, "unmapped read");
        $display("test write done");
    endtask

    task automatic t_instr;
        int b[4] = '{0, 1, 2, 1}; // Enable, disable, return, disable
        logic [7:0] e[4] = '{8'h80, 8'h00, 8'h80, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            pulse(b[i]);
            reg_rd(OFS_MASTER_CTL, d);
            chk_reg(d, e[i], "instruction effect");
        end
        $display("test instructions done");
    endtask

    task automatic t_single_edge;
        logic [7:0] d;
        logic got;
        reg_wr(OFS_EDGE_SEL, 8'h01); // Pin 0 on rising edge
        reg_wr(OFS_MASK, 8'hff);
        set_pin(0, 1'b1);
        chk_bit(irq_out, 1'b1, "rise seen");
        chk_bit(core_irq_out, 1'b0, "gated while disabled");
        reg_wr(OFS_STATUS, 8'h01);
        set_pin(0, 1'b0);
        reg_rd(OFS_STATUS, d);
        chk_reg(d, 8'h00, "fall ignored");
        set_pin(0, 1'b1);
        repeat (6) @(posedge clk_sys_in);
        #1 chk_bit(core_irq_out, 1'b0, "still gated");
        // Slow core: answers three cycles into the offer
        ack_delay <= 4'h3;
        ack_en <= 1'b1;
        pulse(0);
        wait_take(got);
        chk_bit(got, 1'b1, "latched request delivered");
        chk_vec(taken_vector, VEC_PERIPH_BASE, "pin 0 vector");
        ack_en <= 1'b0;
        reg_rd(OFS_MASTER_CTL, d);
        chk_reg(d, 8'h00, "ack clears enable");
        reg_rd(OFS_STATUS, d);
        chk_reg(d, 8'h00, "ack clears source");
        // Pin 1 keeps its falling choice: rise ignored, fall latched
        set_pin(1, 1'b1);
        reg_rd(OFS_STATUS, d);
        chk_reg(d, 8'h00, "rise ignored on falling pin");
        set_pin(1, 1'b0);
        reg_rd(OFS_STATUS, d);
        chk_reg(d, 8'h02, "falling choice seen");
        reg_wr(OFS_STATUS, 8'h02);
        $display("test single edge done");
    endtask

    task automatic t_any_edge;
        logic [7:0] d;
        logic got;
        set_pin(5, 1'b1);
        reg_rd(OFS_STATUS, d);
        chk_reg(d, 8'h20, "any edge rise");
        reg_wr(OFS_STATUS, 8'h20);
        set_pin(5, 1'b0);
        reg_rd(OFS_STATUS, d);
        chk_reg(d, 8'h20, "any edge fall");
        reg_wr(OFS_MASK, 8'h00);
        #1 chk_bit(irq_out, 1'b0, "masked line");
        reg_wr(OFS_MASK, 8'hff);
        #1 chk_bit(irq_out, 1'b1, "unmasked line");
        // Prompt core this time
        ack_delay <= 4'h0;
        ack_en <= 1'b1;
        pulse(2);
        wait_take(got);
        chk_bit(got, 1'b1, "offer after return");
        chk_vec(taken_vector, VEC_PERIPH_BASE + 16'h000a, "pin 5 vector");
        ack_en <= 1'b0;
        $display("test any edge done");
    endtask

    task automatic t_traps;
        int b[4] = '{4, 5, 6, 3}; // Illegal, oscillator, watchdog oscillator, watchdog
        logic [15:0] v[4] = '{VEC_ILLEGAL, VEC_OSC_FAIL, VEC_WDT_OSC_FAIL, VEC_WATCHDOG};
        logic got;
        ack_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            pulse(b[i]);
            wait_take(got);
            chk_bit(got, 1'b1, "trap offered");
            chk_vec(taken_vector, v[i], "trap vector");
        end
        ack_en <= 1'b0;
        $display("test traps done");
    endtask

    // ****************************************
    // Run control
    // ****************************************
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 130 cycles the tests need
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            report_and_stop();
        end
    end

    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        t_reset();
        t_write();
        t_instr();
        t_single_edge();
        t_any_edge();
        t_traps();
        report_and_stop();
    end
endmodule
`default_nettype wire
